// file: mpas_pkg.sv
/*
 * Shared constants of the multiprocessor serial port: register offsets,
 * field positions, reset values and the bit period.
 * Assumes one 50 MHz clock; the bit rate is a fixed divider of it.
 */
package mpas_pkg;

    // =========================================================
    // Register offsets (word index on the plain register port)
    localparam logic [2:0] MPAS_OFS_CTRL   = 3'h0;
    localparam logic [2:0] MPAS_OFS_STATUS = 3'h1;
    localparam logic [2:0] MPAS_OFS_TXDATA = 3'h2;
    localparam logic [2:0] MPAS_OFS_RXDATA = 3'h3;
    localparam logic [2:0] MPAS_OFS_BRKPIN = 3'h4;

    // =========================================================
    // Control register fields
    localparam int MPAS_CTL_TX_EN     = 0;
    localparam int MPAS_CTL_RX_EN     = 1;
    localparam int MPAS_CTL_TXE_IE    = 2;
    localparam int MPAS_CTL_TX_END_FLAG_IE   = 3;
    localparam int MPAS_CTL_RX_IE     = 4;
    localparam int MPAS_CTL_MP_WAIT   = 5;
    localparam int MPAS_CTL_DATA7     = 6;
    localparam int MPAS_CTL_STOP2     = 7;
    localparam logic [7:0] MPAS_CTRL_RESET = 8'h00;

    // =========================================================
    // Status register fields
    localparam int MPAS_ST_MPB_TX  = 0;
    localparam int MPAS_ST_MPB_RX  = 1;
    localparam int MPAS_ST_TX_END  = 2;
    localparam int MPAS_ST_FRAMING = 4;
    localparam int MPAS_ST_OVERRUN = 5;
    localparam int MPAS_ST_RX_FULL = 6;
    localparam int MPAS_ST_TX_EMPTY = 7;

    // =========================================================
    // Break pin register fields
    localparam int MPAS_BP_DATA  = 0;
    localparam int MPAS_BP_DIR   = 1;
    localparam int MPAS_BP_RXPIN = 2;

    // =========================================================
    // Timing: clock cycles per serial bit
    localparam int         MPAS_BIT_CYCLES = 16;
    localparam logic [7:0] MPAS_BIT_LAST   = 8'(MPAS_BIT_CYCLES - 1);
    localparam logic [7:0] MPAS_BIT_HALF   = 8'(MPAS_BIT_CYCLES / 2);

    typedef enum logic [2:0] {MPAS_IDLE, MPAS_START, MPAS_DATA, MPAS_MPB,
                              MPAS_STOP} mpas_state_type;

endpackage : mpas_pkg

// file: mpas_serial_port.sv
/*
 * Multiprocessor-format serial port: transmitter with multiprocessor bit,
 * ID-wait receiver, status flags and error handling. Assumes a plain register
 * port (read data one cycle after the strobe) and rxd synchronous to ref_clk.
 */
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module mpas_serial_port
    import mpas_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       rxd,
    output logic            txd,
    output logic            tx_empty_irq,
    output logic            tx_end_irq,
    output logic            rx_full_irq,
    output logic            rx_error_irq
);

    logic [7:0]     ctrl_r;
    logic           tx_empty_flag_r, tx_end_flag_r, rx_full_flag_r;
    logic           overrun_flag_r, framing_err_flag_r;
    logic           mp_bit_to_send_r, mp_bit_rcvd_r;
    logic [7:0]     tx_holding_reg_r, tx_shift_reg_r;
    logic [7:0]     rx_holding_reg_r, rx_shift_reg_r;
    logic           break_pin_data_r, break_pin_dir_r;
    logic           tx_mpb_r, rx_mpb_r;
    mpas_state_type tx_state_r, rx_state_r;
    logic [7:0]     tx_div_r, rx_div_r;
    logic [2:0]     tx_idx_r, rx_idx_r;
    logic           tx_stop2_r;
    logic [7:0]     rdata_r;
    logic           txd_r;

    logic tx_en, rx_en, data7, tx_tick, rx_tick, tx_load, rx_done, rx_accept;
    logic st_wr, ctl_wr, rx_blocked;
    logic [2:0] last_idx;

    assign tx_en    = ctrl_r[MPAS_CTL_TX_EN];
    assign rx_en    = ctrl_r[MPAS_CTL_RX_EN];
    assign data7    = ctrl_r[MPAS_CTL_DATA7];
    assign last_idx = data7 ? 3'h6 : 3'h7;
    assign st_wr    = reg_wr && reg_addr == MPAS_OFS_STATUS;
    assign ctl_wr   = reg_wr && reg_addr == MPAS_OFS_CTRL;
    assign tx_tick  = tx_div_r == MPAS_BIT_LAST;
    assign rx_tick  = rx_div_r == MPAS_BIT_LAST;
    // Load from idle, or straight after the last stop bit when data waits
    assign tx_load  = tx_en && !tx_empty_flag_r &&
                      (tx_state_r == MPAS_IDLE ||
                       (tx_state_r == MPAS_STOP && tx_tick && !tx_stop2_r));
    assign rx_blocked = overrun_flag_r || framing_err_flag_r || !rx_en;
    assign rx_done    = rx_state_r == MPAS_STOP && rx_tick;
    // Frames with bit 0 are dropped silently while waiting for an ID
    assign rx_accept  = rx_done && !(ctrl_r[MPAS_CTL_MP_WAIT] && !rx_mpb_r);

    // =========================================================
    // Control and break pin registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r           <= MPAS_CTRL_RESET;
            break_pin_data_r <= 1'b0;
            break_pin_dir_r  <= 1'b0;
            tx_holding_reg_r <= 8'h00;
            mp_bit_to_send_r <= 1'b0;
        end else begin
            if (ctl_wr) begin
                ctrl_r <= reg_wdata;
            end else if (rx_accept && rx_mpb_r) begin
                ctrl_r[MPAS_CTL_MP_WAIT] <= 1'b0;
            end
            if (reg_wr && reg_addr == MPAS_OFS_BRKPIN) begin
                break_pin_data_r <= reg_wdata[MPAS_BP_DATA];
                break_pin_dir_r  <= reg_wdata[MPAS_BP_DIR];
            end
            if (reg_wr && reg_addr == MPAS_OFS_TXDATA) begin
                tx_holding_reg_r <= reg_wdata;
            end
            if (st_wr) begin
                mp_bit_to_send_r <= reg_wdata[MPAS_ST_MPB_TX];
            end
        end
    end

    // =========================================================
    // Status flags: writing 0 clears all but tx end, a hardware set in the same cycle wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_empty_flag_r    <= 1'b1;
            tx_end_flag_r      <= 1'b1;
            rx_full_flag_r     <= 1'b0;
            overrun_flag_r     <= 1'b0;
            framing_err_flag_r <= 1'b0;
        end else begin
            if (!tx_en || tx_load) begin
                tx_empty_flag_r <= 1'b1;
            end else if (st_wr && !reg_wdata[MPAS_ST_TX_EMPTY]) begin
                tx_empty_flag_r <= 1'b0;
            end
            if (!tx_en || (tx_state_r == MPAS_MPB && tx_tick && tx_empty_flag_r)) begin
                tx_end_flag_r <= 1'b1;
            end else if (tx_load) begin
                tx_end_flag_r <= 1'b0;
            end
            if (rx_accept && !rx_full_flag_r && rxd) begin
                rx_full_flag_r <= 1'b1;
            end else if (st_wr && !reg_wdata[MPAS_ST_RX_FULL]) begin
                rx_full_flag_r <= 1'b0;
            end
            if (rx_accept && rx_full_flag_r) begin
                overrun_flag_r <= 1'b1;
            end else if (st_wr && !reg_wdata[MPAS_ST_OVERRUN]) begin
                overrun_flag_r <= 1'b0;
            end
            if (rx_accept && !rx_full_flag_r && !rxd) begin
                framing_err_flag_r <= 1'b1;
            end else if (st_wr && !reg_wdata[MPAS_ST_FRAMING]) begin
                framing_err_flag_r <= 1'b0;
            end
        end
    end

    // =========================================================
    // Transmitter: start, data, one mp bit, stop; no parity slot exists
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_r     <= MPAS_IDLE;
            tx_div_r       <= 8'h00;
            tx_idx_r       <= 3'h0;
            tx_shift_reg_r <= 8'h00;
            tx_mpb_r       <= 1'b0;
            tx_stop2_r     <= 1'b0;
        end else if (!tx_en) begin
            tx_state_r     <= MPAS_IDLE;
            tx_shift_reg_r <= 8'h00;
            tx_div_r       <= 8'h00;
        end else if (tx_load) begin
            tx_state_r     <= MPAS_START;
            tx_shift_reg_r <= tx_holding_reg_r;
            tx_mpb_r       <= mp_bit_to_send_r;
            tx_div_r       <= 8'h00;
            tx_idx_r       <= 3'h0;
        end else if (tx_state_r != MPAS_IDLE) begin
            tx_div_r <= tx_tick ? 8'h00 : tx_div_r + 8'h01;
            if (tx_tick) begin
                case (tx_state_r)
                    MPAS_START: tx_state_r <= MPAS_DATA;
                    MPAS_DATA: begin
                        tx_idx_r <= tx_idx_r + 3'h1;
                        if (tx_idx_r == last_idx) begin
                            tx_state_r <= MPAS_MPB;
                        end
                    end
                    MPAS_MPB: begin
                        tx_state_r <= MPAS_STOP;
                        tx_stop2_r <= ctrl_r[MPAS_CTL_STOP2];
                    end
                    MPAS_STOP: begin
                        if (tx_stop2_r) begin
                            tx_stop2_r <= 1'b0;
                        end else begin
                            tx_state_r <= MPAS_IDLE;
                        end
                    end
                    default: tx_state_r <= MPAS_IDLE;
                endcase
            end
        end
    end

    // Line level follows the state; break pin data drives it while tx is off and the break pin direction bit is set, else it idles high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            txd_r <= 1'b1;
        end else if (!tx_en) begin
            txd_r <= break_pin_dir_r ? break_pin_data_r : 1'b1;
        end else begin
            case (tx_state_r)
                MPAS_START: txd_r <= 1'b0;
                MPAS_DATA:  txd_r <= tx_shift_reg_r[tx_idx_r];
                MPAS_MPB:   txd_r <= tx_mpb_r;
                default:    txd_r <= 1'b1;
            endcase
        end
    end

    // =========================================================
    // Receiver: mid-bit sampling, only the first stop bit is checked
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_r     <= MPAS_IDLE;
            rx_div_r       <= 8'h00;
            rx_idx_r       <= 3'h0;
            rx_shift_reg_r <= 8'h00;
            rx_mpb_r       <= 1'b0;
        end else if (rx_state_r == MPAS_IDLE) begin
            if (!rx_blocked && !rxd) begin
                rx_state_r     <= MPAS_START;
                rx_div_r       <= MPAS_BIT_HALF;
                rx_shift_reg_r <= 8'h00;
                rx_idx_r       <= 3'h0;
            end
        end else begin
            rx_div_r <= rx_tick ? 8'h00 : rx_div_r + 8'h01;
            if (rx_tick) begin
                case (rx_state_r)
                    // A glitch shorter than half a bit is not a start bit
                    MPAS_START: rx_state_r <= rxd ? MPAS_IDLE : MPAS_DATA;
                    MPAS_DATA: begin
                        rx_shift_reg_r[rx_idx_r] <= rxd;
                        rx_idx_r <= rx_idx_r + 3'h1;
                        if (rx_idx_r == last_idx) begin
                            rx_state_r <= MPAS_MPB;
                        end
                    end
                    MPAS_MPB: begin
                        rx_mpb_r   <= rxd;
                        rx_state_r <= MPAS_STOP;
                    end
                    MPAS_STOP: rx_state_r <= MPAS_IDLE;
                    default: rx_state_r <= MPAS_IDLE;
                endcase
            end
        end
    end

    // A bad stop bit still stores the byte; a full holding register keeps its own
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_holding_reg_r <= 8'h00;
            mp_bit_rcvd_r    <= 1'b0;
        end else if (rx_accept && !rx_full_flag_r) begin
            rx_holding_reg_r <= rx_shift_reg_r;
            mp_bit_rcvd_r    <= rx_mpb_r;
        end
    end

    // =========================================================
    // Register read port and interrupt requests
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (!reg_rd) begin
            rdata_r <= 8'h00;
        end else if (reg_addr == MPAS_OFS_CTRL) begin
            rdata_r <= ctrl_r;
        end else if (reg_addr == MPAS_OFS_STATUS) begin
            rdata_r <= {tx_empty_flag_r, rx_full_flag_r, overrun_flag_r, framing_err_flag_r,
                        1'b0, tx_end_flag_r, mp_bit_rcvd_r, mp_bit_to_send_r};
        end else if (reg_addr == MPAS_OFS_TXDATA) begin
            rdata_r <= tx_holding_reg_r;
        end else if (reg_addr == MPAS_OFS_RXDATA) begin
            rdata_r <= rx_holding_reg_r;
        end else if (reg_addr == MPAS_OFS_BRKPIN) begin
            rdata_r <= {5'h00, rxd, break_pin_dir_r, break_pin_data_r};
        end else begin
            rdata_r <= 8'h00;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_empty_irq <= 1'b0;
            tx_end_irq   <= 1'b0;
            rx_full_irq  <= 1'b0;
            rx_error_irq <= 1'b0;
        end else begin
            tx_empty_irq <= tx_empty_flag_r && ctrl_r[MPAS_CTL_TXE_IE] && tx_en;
            tx_end_irq   <= tx_end_flag_r && ctrl_r[MPAS_CTL_TX_END_FLAG_IE] && tx_en;
            rx_full_irq  <= rx_full_flag_r && ctrl_r[MPAS_CTL_RX_IE];
            rx_error_irq <= (overrun_flag_r || framing_err_flag_r) &&
                            ctrl_r[MPAS_CTL_RX_IE];
        end
    end

    assign reg_rdata = rdata_r;
    assign txd       = txd_r;

    // =========================================================
    // Checks
    AST_START_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_en && tx_state_r == MPAS_START |=> !txd_r) else $error("start bit not low");
    AST_LOAD_EMPTY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_load |=> tx_empty_flag_r && tx_state_r == MPAS_START)
        else $error("load did not set empty and start");
    AST_MARK: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_en && tx_state_r == MPAS_IDLE |=> txd_r) else $error("idle line not high");
    AST_MPB_OUT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_en && tx_state_r == MPAS_MPB |=> txd_r == tx_mpb_r) else $error("mp bit wrong");
    AST_TX_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_en && tx_state_r == MPAS_MPB && tx_tick && tx_empty_flag_r |=> tx_end_flag_r)
        else $error("end flag not set");
    AST_OVERRUN_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rx_accept && rx_full_flag_r |=> overrun_flag_r && $stable(rx_holding_reg_r))
        else $error("overrun mishandled");
    AST_BLOCKED: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rx_state_r == MPAS_IDLE && (overrun_flag_r || framing_err_flag_r) |=>
        rx_state_r == MPAS_IDLE) else $error("receive resumed under error");
    AST_ID_ACCEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rx_accept && rx_mpb_r && ctrl_r[MPAS_CTL_MP_WAIT] && !ctl_wr |=>
        !ctrl_r[MPAS_CTL_MP_WAIT]) else $error("wait not cleared on id");
    AST_DISCARD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rx_done && ctrl_r[MPAS_CTL_MP_WAIT] && !rx_mpb_r |=>
        $stable(rx_full_flag_r) || !rx_full_flag_r) else $error("data frame not skipped");
    AST_RX_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rx_full_flag_r && ctrl_r[MPAS_CTL_RX_IE] |=> rx_full_irq) else $error("no rx irq");

endmodule : mpas_serial_port

`default_nettype wire

// file: mpas_far_station.sv
/*
 * Far-side station model: sends frames on rxd, decodes frames seen on txd.
 * Assumes 16 clocks per bit, an idle-high shared line and 7- or 8-bit receive chosen by n7.
 */
`timescale 1ns/100ps
`default_nettype none

module mpas_far_station
    import mpas_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       txd,
    input  wire logic       n7,
    output logic            rxd,
    output logic            got,
    output logic      [9:0] word
);
    logic [9:0] s;
    int         nb;

    initial begin
        rxd = 1'b1;
        got = 1'b0;
        word = 10'h000;
    end

    // =========================================================
    // Sender: caller picks mp 1 for an ID, then 0 for payload
    task automatic send(input logic [7:0] d, input logic mp, input logic stp);
        logic [10:0] f;
        f = {stp, mp, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge ref_clk);
            rxd <= f[i];
            repeat (MPAS_BIT_CYCLES - 1) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        rxd <= 1'b1;
        repeat (2 * MPAS_BIT_CYCLES) @(posedge ref_clk);
    endtask : send

    task automatic hold(input logic v);
        @(posedge ref_clk);
        rxd <= v;
    endtask : hold

    // =========================================================
    // Decoder: mid-bit sampling; word is {stop, mp, data}
    always begin
        @(negedge txd);
        nb = n7 ? 7 : 8;
        s = 10'h000;
        repeat (MPAS_BIT_CYCLES / 2) @(posedge ref_clk);
        for (int i = 0; i < nb + 2; i++) begin
            repeat (MPAS_BIT_CYCLES) @(posedge ref_clk);
            s[i] = txd;
        end
        got <= 1'b1;
        word <= n7 ? {s[8], s[7], 1'b0, s[6:0]} : s;
        @(posedge ref_clk);
        got <= 1'b0;
    end

endmodule : mpas_far_station

`default_nettype wire

// file: tb_top.sv
/*
 * Self-checking bench of the multiprocessor serial port.
 * Assumes the far station model and the 16-clock bit period.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top
    import mpas_pkg::*;
;
    logic       ref_clk;
    logic       rst_n;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       rxd;
    logic       txd;
    logic [3:0] irqs;
    logic       n7;
    logic       got;
    logic [9:0] word;
    logic       rd_d;
    logic [7:0] d;
    logic       mp;
    logic [7:0] rd_q[$];
    logic [9:0] fr_q[$];
    int         errors;
    int         n_tests;
    int         cyc;

    mpas_serial_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rxd(rxd), .txd(txd), .tx_empty_irq(irqs[0]), .tx_end_irq(irqs[1]),
        .rx_full_irq(irqs[2]), .rx_error_irq(irqs[3]));

    mpas_far_station station (.ref_clk(ref_clk), .txd(txd), .n7(n7), .rxd(rxd),
        .got(got), .word(word));

    always #10 ref_clk = ~ref_clk;

    // =========================================================
    // Checking and closing
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] s);
        n_tests++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, s);
            errors++;
        end
    endtask : chk

    task automatic complete_run;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // Results are matched against the oldest note as they appear
    always @(posedge ref_clk) begin
        if (rd_d)
            chk("reg_rdata", rd_q.size() ? {2'b00, rd_q.pop_front()} : 'x, {2'b00, reg_rdata});
        rd_d <= reg_rd;
        if (got)
            chk("tx frame", fr_q.size() ? fr_q.pop_front() : 'x, word);
        cyc++;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end

    // =========================================================
    // Register port and transmit helpers
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic wait_irq(input int k, input int lim);
        int i;
        i = 0;
        while (irqs[k] !== 1'b1 && i < lim) begin
            @(posedge ref_clk);
            i++;
        end
        chk("irq wait", 10'h001, 10'(i < lim));
    endtask : wait_irq

    // Data first, then mp bit and flag clear in one write, so the load sees both
    task automatic tx_byte(input logic [7:0] v, input logic b);
        wait_irq(0, 600);
        wr(MPAS_OFS_TXDATA, v);
        wr(MPAS_OFS_STATUS, {7'h38, b});
        repeat (4) @(posedge ref_clk);
    endtask : tx_byte

    // =========================================================
    // Main sequence
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        n7 = 1'b0;
        rd_d = 1'b0;
        errors = 0;
        n_tests = 0;
        cyc = 0;
        void'($urandom(61119));
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk("txd idle", 10'h001, 10'(txd));
        rd(MPAS_OFS_CTRL, MPAS_CTRL_RESET);
        rd(MPAS_OFS_STATUS, 8'h84);
        rd(3'h5, 8'h00);
        // Both formats, three frames each, queued back to back
        for (int m = 0; m < 2; m++) begin
            n7 = m[0];
            wr(MPAS_OFS_CTRL, m ? 8'hcd : 8'h0d);
            for (int k = 0; k < 3; k++) begin
                d = 8'($urandom);
                mp = (k == 0);
                fr_q.push_back({1'b1, mp, m ? {1'b0, d[6:0]} : d});
                tx_byte(d, mp);
            end
            wait_irq(1, 1200);
            repeat (2 * MPAS_BIT_CYCLES) @(posedge ref_clk);
            rd(MPAS_OFS_STATUS, 8'h84);
        end
        // Break: line held low for more than a whole frame
        n7 = 1'b0;
        fr_q.push_back(10'h000);
        wr(MPAS_OFS_BRKPIN, 8'h02);
        wr(MPAS_OFS_CTRL, 8'h00);
        repeat (200) @(posedge ref_clk);
        wr(MPAS_OFS_BRKPIN, 8'h00);
        // Receive: ID wait, accept, follow-on data, overrun
        wr(MPAS_OFS_CTRL, 8'h32);
        d = 8'($urandom);
        station.send(d ^ 8'h5a, 1'b0, 1'b1);
        chk("rx_full_irq", 10'h000, 10'(irqs[2]));
        station.send(d, 1'b1, 1'b1);
        wait_irq(2, 40);
        rd(MPAS_OFS_RXDATA, d);
        rd(MPAS_OFS_CTRL, 8'h12);
        wr(MPAS_OFS_STATUS, 8'hbe);
        station.send(~d, 1'b0, 1'b1);
        wait_irq(2, 40);
        rd(MPAS_OFS_RXDATA, ~d);
        station.send(8'(d + 8'h01), 1'b0, 1'b1);
        wait_irq(3, 40);
        rd(MPAS_OFS_RXDATA, ~d);
        wr(MPAS_OFS_STATUS, 8'h80);
        // Framing error, blocked reception, pin readback, resume
        station.send(d, 1'b0, 1'b0);
        wait_irq(3, 40);
        chk("rx_full_irq", 10'h000, 10'(irqs[2]));
        rd(MPAS_OFS_RXDATA, d);
        station.send(8'h3c, 1'b0, 1'b1);
        rd(MPAS_OFS_RXDATA, d);
        station.hold(1'b0);
        repeat (4) @(posedge ref_clk);
        rd(MPAS_OFS_BRKPIN, 8'h00);
        station.hold(1'b1);
        repeat (4) @(posedge ref_clk);
        rd(MPAS_OFS_BRKPIN, 8'h04);
        wr(MPAS_OFS_STATUS, 8'he0);
        station.send(8'ha5, 1'b1, 1'b1);
        wait_irq(2, 40);
        rd(MPAS_OFS_RXDATA, 8'ha5);
        repeat (4) @(posedge ref_clk);
        if (rd_q.size() != 0 || fr_q.size() != 0)
            errors++;
        complete_run();
    end

endmodule : tb_top

`default_nettype wire
